// File: design/pfs_status_bank.sv
// read-only measurement and status register bank of the pressure controller
`timescale 1ns/10ps
`include "pfs_defs.svh"
module pfs_status_bank
  import pfs_pkg::*;
#(
  parameter int FLASH_CYC = `PFS_FLASH_HALF_MS * `PFS_CLK_KHZ
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // measurements and settings
  input  wire pfs_meas_t   meas,
  input  wire pfs_cfg_t    cfg,
  input  wire pfs_limits_t span_lim,
  input  wire pfs_limits_t alarm_lim,
  input  wire logic        autotune,
  input  wire logic        fb_lost_in,
  input  wire logic        sns_fault_in,
  // register access
  input  wire logic        rd_req,
  input  wire logic        wr_req,
  input  wire logic [15:0] reg_addr,
  output logic      [15:0] rd_data,
  output logic             rd_ack,
  output logic             wr_reject,
  // indicator
  output logic             red_led
);

  function automatic logic [7:0] pfs_isqrt(input logic [15:0] v);
    logic [7:0]  r;
    logic [15:0] t;
    r = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      r[i] = 1'b1;
      t = 16'(r) * 16'(r);
      if (t > v) begin
        r[i] = 1'b0;
      end
    end
    return r;
  endfunction : pfs_isqrt

  // registers
  logic [15:0] diff_pressure;
  logic [31:0] flow_rate;
  logic [15:0] air_velocity;
  logic [15:0] output_percent;
  logic [31:0] max_flow;
  logic        span_out_of_range;
  logic        alarm_out_of_range;
  logic        feedback_missing;
  logic        sensing_element_failure;
  logic [31:0] flash_cnt;
  logic        flash_phase;

  // flow computation
  wire  [15:0] dp_pos      = meas.dp[15] ? 16'h0000 : meas.dp;
  wire  [7:0]  dp_root     = pfs_isqrt(dp_pos);
  wire         big_range   = (cfg.range == PFS_R4K0) || (cfg.range == PFS_R10K);
  wire  [15:0] vel_clamp   = (meas.vel > `PFS_VEL_MAX) ? `PFS_VEL_MAX : meas.vel;
  wire  [15:0] out_clamp   = (meas.out_lvl > `PFS_OUT_MAX) ? `PFS_OUT_MAX : meas.out_lvl;
  wire  [31:0] flow_k      = 32'(cfg.k_factor) * 32'(dp_root);
  wire  [31:0] flow_area   = (32'(cfg.duct_area) * 32'(air_velocity)) / `PFS_AREA_DIV;
  wire  [31:0] next_flow   = (cfg.k_factor != 16'h0000) ? flow_k :
                             cfg.vel_en ? flow_area : 32'h00000000;

  // maximum flow computation
  logic [7:0]  max_root;
  always_comb begin
    case (cfg.range)
      PFS_R1K0: max_root = `PFS_SQRT_1K0;
      PFS_R2K0: max_root = `PFS_SQRT_2K0;
      PFS_R4K0: max_root = `PFS_SQRT_4K0;
      default:  max_root = `PFS_SQRT_10K;
    endcase
  end
  wire  [31:0] max_k       = 32'(cfg.k_factor) * 32'(max_root);
  wire  [31:0] max_area    = (32'(cfg.duct_area) * 32'(`PFS_VEL_MAX)) / `PFS_AREA_DIV;
  wire  [31:0] next_max    = (cfg.k_factor != 16'h0000) ? max_k : max_area;

  // word split with saturation on small ranges
  wire  [15:0] flow_hi_w   = big_range ? flow_rate[31:16] : 16'h0000;
  wire  [15:0] flow_lo_w   = (!big_range && flow_rate[31:16] != 16'h0000) ? 16'hFFFF :
                             flow_rate[15:0];
  wire  [15:0] max_hi_w    = big_range ? max_flow[31:16] : 16'h0000;
  wire  [15:0] max_lo_w    = (!big_range && max_flow[31:16] != 16'h0000) ? 16'hFFFF :
                             max_flow[15:0];

  // range checks
  wire         dp_neg      = meas.dp[15];
  wire         span_p      = dp_neg || (dp_pos < span_lim.p_lo) || (dp_pos > span_lim.p_hi);
  wire         span_f      = (next_flow < 32'(span_lim.f_lo)) || (next_flow > 32'(span_lim.f_hi));
  wire         span_v      = cfg.vel_en &&
                             ((vel_clamp < span_lim.v_lo) || (vel_clamp > span_lim.v_hi));
  wire         alarm_p     = dp_neg || (dp_pos < alarm_lim.p_lo) || (dp_pos > alarm_lim.p_hi);
  wire         alarm_f     = (next_flow < 32'(alarm_lim.f_lo)) ||
                             (next_flow > 32'(alarm_lim.f_hi));
  wire         alarm_v     = cfg.vel_en &&
                             ((vel_clamp < alarm_lim.v_lo) || (vel_clamp > alarm_lim.v_hi));
  wire         next_span   = !autotune && (span_p || span_f || span_v);
  wire         next_alarm  = !autotune && (alarm_p || alarm_f || alarm_v);

  // measurement registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      diff_pressure  <= `PFS_RESET_VALUE;
      flow_rate      <= 32'h00000000;
      air_velocity   <= `PFS_RESET_VALUE;
      output_percent <= `PFS_RESET_VALUE;
      max_flow       <= 32'h00000000;
    end else if (ce) begin
      diff_pressure  <= meas.dp;
      flow_rate      <= next_flow;
      output_percent <= out_clamp;
      max_flow       <= next_max;
      if (cfg.vel_en) begin
        air_velocity <= vel_clamp;
      end
    end
  end

  // status flags
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      span_out_of_range       <= 1'b0;
      alarm_out_of_range      <= 1'b0;
      feedback_missing        <= 1'b0;
      sensing_element_failure <= 1'b0;
    end else if (ce) begin
      span_out_of_range       <= next_span;
      alarm_out_of_range      <= next_alarm;
      feedback_missing        <= fb_lost_in;
      sensing_element_failure <= sns_fault_in;
    end
  end

  // red led flasher
  wire fault_any = feedback_missing || sensing_element_failure;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flash_cnt   <= 32'h00000000;
      flash_phase <= 1'b0;
    end else if (ce) begin
      if (!fault_any) begin
        flash_cnt   <= 32'h00000000;
        flash_phase <= 1'b0;
      end else if (flash_cnt >= 32'(FLASH_CYC - 1)) begin
        flash_cnt   <= 32'h00000000;
        flash_phase <= !flash_phase;
      end else begin
        flash_cnt   <= flash_cnt + 32'h00000001;
      end
    end
  end
  assign red_led = fault_any && !flash_phase;

  // read decode
  logic [15:0] next_rd_data;
  always_comb begin
    case (reg_addr)
      `PFS_ADDR_DIFF:      next_rd_data = diff_pressure;
      `PFS_ADDR_FLOW_HI:   next_rd_data = flow_hi_w;
      `PFS_ADDR_FLOW_LO:   next_rd_data = flow_lo_w;
      `PFS_ADDR_VEL:       next_rd_data = air_velocity;
      `PFS_ADDR_OUT:       next_rd_data = output_percent;
      `PFS_ADDR_MAX_HI:    next_rd_data = max_hi_w;
      `PFS_ADDR_MAX_LO:    next_rd_data = max_lo_w;
      `PFS_ADDR_SPAN:      next_rd_data = {15'h0000, span_out_of_range};
      `PFS_ADDR_ALARM:     next_rd_data = {15'h0000, alarm_out_of_range};
      `PFS_ADDR_FB_LOST:   next_rd_data = {15'h0000, feedback_missing};
      `PFS_ADDR_SNS_FAULT: next_rd_data = {15'h0000, sensing_element_failure};
      default:             next_rd_data = 16'h0000;
    endcase
  end

  // read answer and write refusal
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rd_data   <= 16'h0000;
      rd_ack    <= 1'b0;
      wr_reject <= 1'b0;
    end else if (ce) begin
      rd_ack    <= rd_req && !wr_req;
      wr_reject <= wr_req;
      if (rd_req && !wr_req) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_flow_hi_word: assert property (ce ##1 (rd_ack && $past(reg_addr) == `PFS_ADDR_FLOW_HI
      && $past(rd_req) && $past(ce) && !big_range) |-> rd_data == 16'h0000)
    else $error("flow high word nonzero on small range");
  a_read_answer: assert property ((ce && rd_req && !wr_req) |=> rd_ack)
    else $error("read not answered");
  a_write_refused: assert property ((ce && wr_req) |=> (wr_reject && !rd_ack))
    else $error("write not refused");
  a_span_tune: assert property ((ce && autotune) |=> !span_out_of_range)
    else $error("span flag active during autotune");
  a_alarm_tune: assert property ((ce && autotune) |=> !alarm_out_of_range)
    else $error("alarm flag active during autotune");
  a_vel_hold: assert property ((ce && !cfg.vel_en) |=> $stable(air_velocity))
    else $error("velocity changed while disabled");
  a_vel_range: assert property (air_velocity <= `PFS_VEL_MAX)
    else $error("velocity above range");
  a_out_range: assert property (output_percent <= `PFS_OUT_MAX)
    else $error("output above range");
  a_flow_kfac: assert property ((ce && cfg.k_factor != 16'h0000)
      |=> flow_rate == $past(flow_k))
    else $error("flow not from k-factor");
  a_flow_split: assert property ((ce && rd_req && !wr_req && reg_addr == `PFS_ADDR_FLOW_LO
      && big_range) |=> rd_data == $past(flow_rate[15:0]))
    else $error("flow low word mismatch");
  a_fb_led: assert property ((feedback_missing && !flash_phase) |-> red_led)
    else $error("led dark on feedback loss");
  a_led_off: assert property (!fault_any |-> !red_led)
    else $error("led lit without fault");
  a_span_set: assert property ((ce && !autotune && dp_neg) |=> span_out_of_range)
    else $error("span flag missed negative pressure");
  a_alarm_set: assert property ((ce && !autotune && dp_neg) |=> alarm_out_of_range)
    else $error("alarm flag missed negative pressure");

  // handshake checks
  a_ack_idle: assert property ((ce && !rd_req) |=> !rd_ack)
    else $error("read answered without request");
  a_reject_idle: assert property ((ce && !wr_req) |=> !wr_reject)
    else $error("write refused without attempt");
  a_rd_hold: assert property ((ce && !(rd_req && !wr_req)) |=> $stable(rd_data))
    else $error("read data moved without read");
  a_rd_unmapped: assert property ((ce && rd_req && !wr_req && reg_addr > `PFS_ADDR_SNS_FAULT)
      |=> rd_data == 16'h0000)
    else $error("unmapped register not zero");

  // clock enable freeze checks
  a_freeze_ack: assert property (!ce |=> $stable(rd_ack))
    else $error("ack moved while frozen");
  a_freeze_data: assert property (!ce |=> $stable(rd_data))
    else $error("read data moved while frozen");
  a_freeze_flow: assert property (!ce |=> $stable(flow_rate))
    else $error("flow moved while frozen");

  // measurement checks
  a_diff_copy: assert property (ce |=> diff_pressure == $past(meas.dp))
    else $error("pressure register not current");
  a_out_copy: assert property ((ce && meas.out_lvl <= `PFS_OUT_MAX)
      |=> output_percent == $past(meas.out_lvl))
    else $error("output register not current");
  a_vel_copy: assert property ((ce && cfg.vel_en && meas.vel <= `PFS_VEL_MAX)
      |=> air_velocity == $past(meas.vel))
    else $error("velocity register not current");
  a_flow_area: assert property ((ce && cfg.k_factor == 16'h0000 && cfg.vel_en)
      |=> flow_rate == $past(flow_area))
    else $error("flow not from duct area");
  a_flow_none: assert property ((ce && cfg.k_factor == 16'h0000 && !cfg.vel_en)
      |=> flow_rate == 32'h00000000)
    else $error("flow without source");
  a_max_kfac: assert property ((ce && cfg.k_factor != 16'h0000)
      |=> max_flow == $past(max_k))
    else $error("max flow not from k-factor");
  a_max_area: assert property ((ce && cfg.k_factor == 16'h0000)
      |=> max_flow == $past(max_area))
    else $error("max flow not from duct area");

  // word split checks
  a_flow_hi_big: assert property (big_range |-> flow_hi_w == flow_rate[31:16])
    else $error("flow high word lost");
  a_flow_lo_big: assert property (big_range |-> flow_lo_w == flow_rate[15:0])
    else $error("flow low word lost");
  a_flow_lo_sat: assert property ((!big_range && flow_rate[31:16] != 16'h0000)
      |-> flow_lo_w == 16'hFFFF)
    else $error("flow low word not saturated");
  a_max_hi_small: assert property (!big_range |-> max_hi_w == 16'h0000)
    else $error("max high word on small range");
  a_max_lo_sat: assert property ((!big_range && max_flow[31:16] != 16'h0000)
      |-> max_lo_w == 16'hFFFF)
    else $error("max low word not saturated");

  // flag and indicator checks
  a_span_dp: assert property ((ce && !autotune && dp_pos > span_lim.p_hi)
      |=> span_out_of_range)
    else $error("span flag missed high pressure");
  a_alarm_dp: assert property ((ce && !autotune && dp_pos > alarm_lim.p_hi)
      |=> alarm_out_of_range)
    else $error("alarm flag missed high pressure");
  a_span_clear: assert property ((ce && !span_p && !span_f && !span_v)
      |=> !span_out_of_range)
    else $error("span flag set within limits");
  a_alarm_clear: assert property ((ce && !alarm_p && !alarm_f && !alarm_v)
      |=> !alarm_out_of_range)
    else $error("alarm flag set within limits");
  a_fb_copy: assert property (ce |=> feedback_missing == $past(fb_lost_in))
    else $error("feedback indicator not current");
  a_sns_copy: assert property (ce |=> sensing_element_failure == $past(sns_fault_in))
    else $error("sensor indicator not current");
  a_sns_led: assert property ((sensing_element_failure && !flash_phase) |-> red_led)
    else $error("led dark on sensor fault");
  a_led_phase: assert property ((fault_any && flash_phase) |-> !red_led)
    else $error("led lit in dark phase");
  a_flash_bound: assert property (flash_cnt < 32'(FLASH_CYC))
    else $error("flash counter overrun");

endmodule : pfs_status_bank

// File: design/pfs_defs.svh
// register addresses, field limits and timing figures of the status bank
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH
`define PFS_ADDR_DIFF      16'h0001
`define PFS_ADDR_FLOW_HI   16'h0002
`define PFS_ADDR_FLOW_LO   16'h0003
`define PFS_ADDR_VEL       16'h0004
`define PFS_ADDR_OUT       16'h0005
`define PFS_ADDR_MAX_HI    16'h0006
`define PFS_ADDR_MAX_LO    16'h0007
`define PFS_ADDR_SPAN      16'h0008
`define PFS_ADDR_ALARM     16'h0009
`define PFS_ADDR_FB_LOST   16'h000A
`define PFS_ADDR_SNS_FAULT 16'h000B
`define PFS_RESET_VALUE    16'h0000
`define PFS_VEL_MAX        16'h012C
`define PFS_OUT_MAX        16'h03E8
`define PFS_AREA_DIV       32'h0000000A
`define PFS_SQRT_1K0       8'h1F
`define PFS_SQRT_2K0       8'h2C
`define PFS_SQRT_4K0       8'h3F
`define PFS_SQRT_10K       8'h64
`define PFS_FLASH_HALF_MS  250
`define PFS_CLK_KHZ        20000
`endif

// File: design/pfs_pkg.sv
// types shared by the pressure and flow status bank
package pfs_pkg;
  typedef enum logic [1:0] {
    PFS_R1K0,
    PFS_R2K0,
    PFS_R4K0,
    PFS_R10K
  } pfs_range_t;

  typedef struct packed {
    logic signed [15:0] dp;
    logic        [15:0] vel;
    logic        [15:0] out_lvl;
  } pfs_meas_t;

  typedef struct packed {
    logic [15:0] p_lo;
    logic [15:0] p_hi;
    logic [15:0] f_lo;
    logic [15:0] f_hi;
    logic [15:0] v_lo;
    logic [15:0] v_hi;
  } pfs_limits_t;

  typedef struct packed {
    logic [15:0] k_factor;
    logic [15:0] duct_area;
    logic        vel_en;
    pfs_range_t  range;
  } pfs_cfg_t;
endpackage : pfs_pkg

// File: sim/pfs_master.sv
// register-reading master model facing the status bank
`timescale 1ns/10ps
module pfs_master (
  // clock
  input  wire logic        mclk,
  // request side
  output logic             rd_req,
  output logic             wr_req,
  output logic      [15:0] reg_addr,
  // answer side
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_ack,
  input  wire logic        wr_reject
);
  initial begin
    rd_req   = 1'b0;
    wr_req   = 1'b0;
    reg_addr = 16'h0000;
  end
  // one input-register request, then a bounded wait for its answer
  task automatic xfer(input logic w, input logic [15:0] a, output logic [15:0] d,
                      output logic ok);
    int i;
    @(posedge mclk);
    #1;
    rd_req   = !w;
    wr_req   = w;
    reg_addr = a;
    @(posedge mclk);
    #1;
    rd_req   = 1'b0;
    wr_req   = 1'b0;
    reg_addr = ~a;
    ok = 1'b0;
    d  = 16'h0000;
    for (i = 0; i < 4 && !ok; i++) begin
      if ((w ? wr_reject : rd_ack) === 1'b1) begin
        ok = 1'b1;
        d  = rd_data;
      end else begin
        @(posedge mclk);
        #1;
      end
    end
  endtask : xfer
endmodule : pfs_master

// File: sim/tb.sv
// self-checking bench of the status bank
`timescale 1ns/10ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t %s", $time, m); end end
module tb;
  import pfs_pkg::*;
  localparam pfs_limits_t WIDE = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};
  logic        mclk, resetn, ce, autotune, fb_lost_in, sns_fault_in;
  logic        rd_req, wr_req, rd_ack, wr_reject, red_led;
  logic [15:0] reg_addr, rd_data;
  pfs_meas_t   meas;
  pfs_cfg_t    cfg;
  pfs_limits_t span_lim, alarm_lim;
  int          n_fail = 0;
  int          check_count = 0;
  pfs_status_bank #(.FLASH_CYC(4)) dut (.mclk(mclk), .resetn(resetn), .ce(ce), .meas(meas),
    .cfg(cfg), .span_lim(span_lim), .alarm_lim(alarm_lim), .autotune(autotune),
    .fb_lost_in(fb_lost_in), .sns_fault_in(sns_fault_in), .rd_req(rd_req), .wr_req(wr_req),
    .reg_addr(reg_addr), .rd_data(rd_data), .rd_ack(rd_ack), .wr_reject(wr_reject),
    .red_led(red_led));
  pfs_master mst (.mclk(mclk), .rd_req(rd_req), .wr_req(wr_req), .reg_addr(reg_addr),
    .rd_data(rd_data), .rd_ack(rd_ack), .wr_reject(wr_reject));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string m);
    logic [15:0] d;
    logic        ok;
    mst.xfer(1'b0, a, d, ok);
    `CHK(ok, 1'b1, "no read ack")
    `CHK(d, e, m)
  endtask : rd
  task automatic leds(input string m);
    int tg;
    logic last;
    tg = 0;
    last = red_led;
    repeat (12) begin
      step(1);
      if (red_led !== last) tg++;
      last = red_led;
    end
    `CHK(tg > 1, 1'b1, m)
  endtask : leds
  task automatic t_flow;
    cfg = '{16'h0003, 16'h0000, 1'b0, PFS_R4K0};
    meas.dp = 16'sh0064;
    step(3);
    rd(16'h0001, 16'h0064, "pressure");
    rd(16'h0002, 16'h0000, "flow hi");
    rd(16'h0003, 16'h001E, "flow lo");
    cfg.k_factor = 16'h03E8;
    cfg.range = PFS_R10K;
    meas.dp = 16'sh2710;
    step(3);
    rd(16'h0002, 16'h0001, "big hi");
    rd(16'h0003, 16'h86A0, "big lo");
    rd(16'h0006, 16'h0001, "max hi");
    rd(16'h0007, 16'h86A0, "max lo");
    cfg.range = PFS_R1K0;
    meas.dp = 16'sh0064;
    step(3);
    rd(16'h0002, 16'h0000, "small hi");
    rd(16'h0003, 16'h2710, "small lo");
    rd(16'h0006, 16'h0000, "small max hi");
    rd(16'h0007, 16'h7918, "small max lo");
    cfg.range = PFS_R2K0;
    meas.dp = 16'sh2710;
    step(3);
    rd(16'h0007, 16'hABE0, "mid max lo");
    rd(16'h0003, 16'hFFFF, "small sat");
    $display("flow test done");
  endtask : t_flow
  task automatic t_vel;
    cfg = '{16'h0000, 16'h0014, 1'b1, PFS_R4K0};
    meas.vel = 16'h0096;
    meas.out_lvl = 16'h03E8;
    step(3);
    rd(16'h0004, 16'h0096, "velocity");
    rd(16'h0003, 16'h012C, "area flow");
    rd(16'h0005, 16'h03E8, "output");
    meas.vel = 16'h0190;
    meas.out_lvl = 16'h07D0;
    step(3);
    rd(16'h0004, 16'h012C, "velocity top");
    rd(16'h0005, 16'h03E8, "output top");
    cfg.vel_en = 1'b0;
    meas.vel = 16'h0032;
    step(3);
    rd(16'h0004, 16'h012C, "velocity frozen");
    rd(16'h0003, 16'h0000, "no flow source");
    $display("velocity test done");
  endtask : t_vel
  task automatic t_flags;
    cfg = '{16'h0003, 16'h0000, 1'b0, PFS_R4K0};
    span_lim.p_hi = 16'h0032;
    step(3);
    rd(16'h0008, 16'h0001, "span set");
    rd(16'h0009, 16'h0000, "alarm clear");
    alarm_lim.p_hi = 16'h0032;
    step(3);
    rd(16'h0009, 16'h0001, "alarm set");
    autotune = 1'b1;
    step(3);
    rd(16'h0008, 16'h0000, "span tune");
    rd(16'h0009, 16'h0000, "alarm tune");
    autotune = 1'b0;
    span_lim = WIDE;
    alarm_lim = WIDE;
    meas.dp = 16'shFFFF;
    step(3);
    rd(16'h0008, 16'h0001, "span negative");
    rd(16'h0009, 16'h0001, "alarm negative");
    meas.dp = 16'sh0064;
    step(3);
    rd(16'h0008, 16'h0000, "span back");
    $display("flag test done");
  endtask : t_flags
  task automatic t_fault;
    logic [15:0] d;
    logic        ok;
    fb_lost_in = 1'b1;
    step(3);
    rd(16'h000A, 16'h0001, "feedback");
    leds("feedback led");
    fb_lost_in = 1'b0;
    sns_fault_in = 1'b1;
    step(3);
    rd(16'h000B, 16'h0001, "sensor");
    rd(16'h000A, 16'h0000, "feedback off");
    leds("sensor led");
    sns_fault_in = 1'b0;
    step(3);
    `CHK(red_led, 1'b0, "led off")
    mst.xfer(1'b1, 16'h0003, d, ok);
    `CHK(ok, 1'b1, "no reject")
    rd(16'h0003, 16'h001E, "after write");
    rd(16'h000C, 16'h0000, "unmapped");
    ce = 1'b0;
    meas.dp = 16'sh0050;
    step(3);
    `CHK(dut.diff_pressure, 16'h0064, "frozen pressure")
    ce = 1'b1;
    meas.dp = 16'sh0064;
    step(2);
    $display("fault and write test done");
  endtask : t_fault
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    autotune = 1'b0;
    fb_lost_in = 1'b0;
    sns_fault_in = 1'b0;
    meas = '0;
    cfg = '{16'h0000, 16'h0000, 1'b0, PFS_R1K0};
    span_lim = WIDE;
    alarm_lim = WIDE;
    step(20);
    resetn = 1'b1;
    t_flow();
    t_vel();
    t_flags();
    t_fault();
    final_report();
  end
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule : tb
